// *** logic/imu_fifo_power_offset_regs.v ***
/*
 * Upper register bank of the motion sensor: axis standby, serial interface
 * select, latched FIFO level, FIFO data port with sample sequencer,
 * identity register and accelerometer offset trims.
 * Assumes a serial front end that turns host transfers into one-cycle
 * read and write strobes on core_clk, and a sensor core that supplies
 * a sample strobe, the sample bytes and the per-byte capture mask.
 */

`include "imu_regs_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module imu_fifo_power_offset_regs #(
	// Arbitrary identity value
	parameter [7:0] PART_IDENTITY_CODE = 8'h5a
) (
	// Clock and reset
	input  wire         core_clk,
	input  wire         reset,
	// Host register port
	input  wire [6:0]   reg_addr,
	input  wire         reg_wr,
	input  wire         reg_rd,
	input  wire [7:0]   reg_wdata,
	output reg  [7:0]   reg_rdata,
	output reg          reg_rvalid,
	// Sensor sample feed
	input  wire         sample_strobe,
	input  wire [111:0] sample_bytes,
	input  wire [13:0]  capture_mask,
	input  wire         fifo_stop_when_full,
	output reg          sampling_busy,
	output reg          buffer_overrun_flag,
	// Pins
	input  wire         address_select_pin,
	output reg  [6:0]   two_wire_address,
	// Power and interface controls
	output reg          accel_x_off,
	output reg          accel_y_off,
	output reg          accel_z_off,
	output reg          gyro_x_off,
	output reg          gyro_y_off,
	output reg          gyro_z_off,
	output reg          two_wire_slave_off,
	// Offset trims, 0.98 mg per step
	output reg  [14:0]  accel_x_trim,
	output reg  [14:0]  accel_y_trim,
	output reg  [14:0]  accel_z_trim
);

	// ----------------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------------
	// Empty marker is reserved, so real data equal to it is pulled one code down
	function [7:0] clamp_data;
		input [7:0] d;
		begin
			clamp_data = (d == `FIFO_EMPTY_VALUE) ? `FIFO_CLAMP_VALUE : d;
		end
	endfunction

	function hit;
		input [6:0] a;
		input [6:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	// ----------------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------------
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	reg [7:0]            fifo_mem [0:1023];
	reg [`FIFO_AW-1:0]   wr_ptr;
	reg [`FIFO_AW-1:0]   rd_ptr;
	reg [10:0]           fifo_count;
	reg [15:0]           level_latch;
	reg                  seq_state;
	reg [3:0]            seq_idx;
	reg [111:0]          sample_snap;
	reg [13:0]           mask_snap;

	// ----------------------------------------------------------------------
	// FIFO push and pop arbitration
	// ----------------------------------------------------------------------
	wire       host_push   = reg_wr && hit(reg_addr, `OFS_FIFO_PORT);
	wire       host_pop    = reg_rd && hit(reg_addr, `OFS_FIFO_PORT);
	wire [7:0] seq_byte    = sample_snap[{seq_idx, 3'b000} +: 8];
	// Host write wins the port; the sequencer simply waits a cycle
	wire       seq_push    = (seq_state == ST_RUN) && !host_push && mask_snap[seq_idx];
	wire       push_req    = host_push || seq_push;
	wire [7:0] push_data   = clamp_data(host_push ? reg_wdata : seq_byte);
	wire       fifo_empty  = (fifo_count == 11'h000);
	wire       fifo_full   = (fifo_count == `FIFO_DEPTH);
	wire       pop_eff     = host_pop && !fifo_empty;
	wire       overflow    = push_req && fifo_full && !pop_eff;
	wire       wr_en       = push_req && !(overflow && fifo_stop_when_full);
	wire       drop_oldest = overflow && !fifo_stop_when_full;
	wire       rd_adv      = pop_eff || drop_oldest;

	reg [10:0] next_count;
	always @* begin
		next_count = fifo_count;
		if (wr_en && !rd_adv)
			next_count = fifo_count + 11'h001;
		else if (!wr_en && rd_adv)
			next_count = fifo_count - 11'h001;
	end

	always @(posedge core_clk) begin
		if (wr_en)
			fifo_mem[wr_ptr] <= push_data;
	end

	always @(posedge core_clk) begin
		if (reset) begin
			wr_ptr              <= {`FIFO_AW{1'b0}};
			rd_ptr              <= {`FIFO_AW{1'b0}};
			fifo_count          <= 11'h000;
			buffer_overrun_flag <= 1'b0;
		end else begin
			if (wr_en)
				wr_ptr <= wr_ptr + 1'b1;
			if (rd_adv)
				rd_ptr <= rd_ptr + 1'b1;
			fifo_count          <= next_count;
			buffer_overrun_flag <= overflow;
		end
	end

	// ----------------------------------------------------------------------
	// Sample sequencer
	// ----------------------------------------------------------------------
	// A strobe while a sample is still draining is ignored
	always @(posedge core_clk) begin
		if (reset) begin
			seq_state     <= ST_IDLE;
			seq_idx       <= 4'h0;
			sample_snap   <= 112'h0;
			mask_snap     <= 14'h0000;
			sampling_busy <= 1'b0;
		end else begin
			case (seq_state)
				ST_IDLE: begin
					if (sample_strobe) begin
						sample_snap   <= sample_bytes;
						mask_snap     <= capture_mask;
						seq_idx       <= 4'h0;
						seq_state     <= ST_RUN;
						sampling_busy <= 1'b1;
					end
				end
				ST_RUN: begin
					if (!host_push) begin
						if (seq_idx == `SAMPLE_LAST_IDX) begin
							seq_state     <= ST_IDLE;
							sampling_busy <= 1'b0;
						end else begin
							seq_idx <= seq_idx + 4'h1;
						end
					end
				end
				default: begin
					seq_state     <= ST_IDLE;
					sampling_busy <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------------
	always @(posedge core_clk) begin
		if (reset) begin
			accel_x_off        <= 1'b0;
			accel_y_off        <= 1'b0;
			accel_z_off        <= 1'b0;
			gyro_x_off         <= 1'b0;
			gyro_y_off         <= 1'b0;
			gyro_z_off         <= 1'b0;
			two_wire_slave_off <= 1'b0;
			accel_x_trim       <= {`RST_TRIM, 7'h00};
			accel_y_trim       <= {`RST_TRIM, 7'h00};
			accel_z_trim       <= {`RST_TRIM, 7'h00};
		end else if (reg_wr) begin
			// Level and identity offsets fall through untouched
			if (hit(reg_addr, `OFS_AXIS_STANDBY)) begin
				accel_x_off <= reg_wdata[`BIT_ACCEL_X_OFF];
				accel_y_off <= reg_wdata[`BIT_ACCEL_Y_OFF];
				accel_z_off <= reg_wdata[`BIT_ACCEL_Z_OFF];
				gyro_x_off  <= reg_wdata[`BIT_GYRO_X_OFF];
				gyro_y_off  <= reg_wdata[`BIT_GYRO_Y_OFF];
				gyro_z_off  <= reg_wdata[`BIT_GYRO_Z_OFF];
			end
			if (hit(reg_addr, `OFS_SERIAL_IF_SELECT))
				two_wire_slave_off <= reg_wdata[`BIT_TWO_WIRE_OFF];
			if (hit(reg_addr, `OFS_ACCEL_X_TRIM_HIGH))
				accel_x_trim[14:7] <= reg_wdata;
			if (hit(reg_addr, `OFS_ACCEL_X_TRIM_LOW))
				accel_x_trim[6:0] <= reg_wdata[7:1];
			if (hit(reg_addr, `OFS_ACCEL_Y_TRIM_HIGH))
				accel_y_trim[14:7] <= reg_wdata;
			if (hit(reg_addr, `OFS_ACCEL_Y_TRIM_LOW))
				accel_y_trim[6:0] <= reg_wdata[7:1];
			if (hit(reg_addr, `OFS_ACCEL_Z_TRIM_HIGH))
				accel_z_trim[14:7] <= reg_wdata;
			if (hit(reg_addr, `OFS_ACCEL_Z_TRIM_LOW))
				accel_z_trim[6:0] <= reg_wdata[7:1];
		end
	end

	// Strap sampled every cycle, never at reset, so a late pin settles
	always @(posedge core_clk) begin
		if (reset)
			two_wire_address <= `TWO_WIRE_ADDR_BASE;
		else
			two_wire_address <= `TWO_WIRE_ADDR_BASE | {6'h00, address_select_pin};
	end

	// ----------------------------------------------------------------------
	// Level latch
	// ----------------------------------------------------------------------
	// Both bytes come from one latch, so a high-then-low pair is coherent
	always @(posedge core_clk) begin
		if (reset)
			level_latch <= 16'h0000;
		else if (reg_rd && hit(reg_addr, `OFS_FIFO_LEVEL_LOW))
			level_latch <= {5'h00, fifo_count};
	end

	// ----------------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------------
	reg [7:0] next_rdata;
	always @* begin
		next_rdata = 8'h00;
		case (reg_addr)
			`OFS_AXIS_STANDBY:
				next_rdata = {2'b00, accel_x_off, accel_y_off, accel_z_off,
					gyro_x_off, gyro_y_off, gyro_z_off};
			`OFS_SERIAL_IF_SELECT:
				next_rdata = {1'b0, two_wire_slave_off, 6'h00};
			`OFS_FIFO_LEVEL_HIGH:
				next_rdata = level_latch[15:8];
			`OFS_FIFO_LEVEL_LOW:
				next_rdata = level_latch[7:0];
			`OFS_FIFO_PORT:
				next_rdata = fifo_empty ? `FIFO_EMPTY_VALUE : fifo_mem[rd_ptr];
			`OFS_DEVICE_IDENTITY:
				next_rdata = PART_IDENTITY_CODE;
			`OFS_ACCEL_X_TRIM_HIGH:
				next_rdata = accel_x_trim[14:7];
			`OFS_ACCEL_X_TRIM_LOW:
				next_rdata = {accel_x_trim[6:0], 1'b0};
			`OFS_ACCEL_Y_TRIM_HIGH:
				next_rdata = accel_y_trim[14:7];
			`OFS_ACCEL_Y_TRIM_LOW:
				next_rdata = {accel_y_trim[6:0], 1'b0};
			`OFS_ACCEL_Z_TRIM_HIGH:
				next_rdata = accel_z_trim[14:7];
			`OFS_ACCEL_Z_TRIM_LOW:
				next_rdata = {accel_z_trim[6:0], 1'b0};
			default:
				next_rdata = 8'h00;
		endcase
	end

	always @(posedge core_clk) begin
		if (reset) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= next_rdata;
		end
	end

endmodule // imu_fifo_power_offset_regs

`default_nettype wire

// *** logic/imu_regs_defs.vh ***
/*
 * Register offsets, field positions, reset values and FIFO sizing for the
 * upper register bank of the motion sensor.
 * Assumes inclusion by bare name from the bank's design file.
 */
`ifndef IMU_REGS_DEFS_VH
`define IMU_REGS_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_AXIS_STANDBY      7'h6c
`define OFS_SERIAL_IF_SELECT  7'h70
`define OFS_FIFO_LEVEL_HIGH   7'h72
`define OFS_FIFO_LEVEL_LOW    7'h73
`define OFS_FIFO_PORT         7'h74
`define OFS_DEVICE_IDENTITY   7'h75
`define OFS_ACCEL_X_TRIM_HIGH 7'h77
`define OFS_ACCEL_X_TRIM_LOW  7'h78
`define OFS_ACCEL_Y_TRIM_HIGH 7'h7a
`define OFS_ACCEL_Y_TRIM_LOW  7'h7b
`define OFS_ACCEL_Z_TRIM_HIGH 7'h7d
`define OFS_ACCEL_Z_TRIM_LOW  7'h7e

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define BIT_ACCEL_X_OFF       5
`define BIT_ACCEL_Y_OFF       4
`define BIT_ACCEL_Z_OFF       3
`define BIT_GYRO_X_OFF        2
`define BIT_GYRO_Y_OFF        1
`define BIT_GYRO_Z_OFF        0
`define BIT_TWO_WIRE_OFF      6
`define MASK_AXIS_STANDBY     8'h3f
`define MASK_SERIAL_IF        8'h40
`define MASK_TRIM_LOW         8'hfe

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_AXIS_STANDBY      8'h00
`define RST_SERIAL_IF         8'h00
`define RST_TRIM              8'h00

// ----------------------------------------------------------------------
// FIFO and sample sizing
// ----------------------------------------------------------------------
`define FIFO_DEPTH            11'h400
`define FIFO_AW               10
`define FIFO_EMPTY_VALUE      8'hff
`define FIFO_CLAMP_VALUE      8'hfe
`define SAMPLE_BYTES          14
`define SAMPLE_LAST_IDX       4'hd
`define TWO_WIRE_ADDR_BASE    7'h68

`endif

// *** tb/imu_regs_properties.sv ***
/* Port assertions for the register bank.
   Assumes a bind onto the bank's top module. */
`timescale 1ns/1ps
`default_nettype none
module imu_regs_properties (
	// Host port
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic [6:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rvalid,
	// Sampling, pins, controls
	input wire logic        sample_strobe,
	input wire logic        sampling_busy,
	input wire logic        address_select_pin,
	input wire logic [6:0]  two_wire_address,
	input wire logic        accel_x_off,
	input wire logic        accel_y_off,
	input wire logic        accel_z_off,
	input wire logic        gyro_x_off,
	input wire logic        gyro_y_off,
	input wire logic        gyro_z_off,
	input wire logic        two_wire_slave_off,
	input wire logic [14:0] accel_x_trim
);
	logic [7:0] wd_q;
	// Avoids slicing a sampled-value function result
	always @(posedge core_clk) wd_q <= reg_wdata;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read got no answer");
	a_rdata_holds: assert property (!reg_rvalid && !$past(reset) |-> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_standby_write: assert property (reg_wr && reg_addr == 7'h6c |=>
		{accel_x_off, accel_y_off, accel_z_off, gyro_x_off, gyro_y_off, gyro_z_off} == wd_q[5:0])
		else $error("standby outputs differ from write");
	a_iface_write: assert property (reg_wr && reg_addr == 7'h70 |=> two_wire_slave_off == wd_q[6])
		else $error("slave off differs from write");
	a_trim_high: assert property (reg_wr && reg_addr == 7'h77 |=> accel_x_trim[14:7] == wd_q)
		else $error("trim high bits wrong");
	a_trim_low: assert property (reg_wr && reg_addr == 7'h78 |=> accel_x_trim[6:0] == wd_q[7:1])
		else $error("trim low bits wrong");
	a_pin_address: assert property (!$past(reset) |->
		two_wire_address == {6'h34, $past(address_select_pin)})
		else $error("bus address does not follow pin");
	a_busy_starts: assert property (sample_strobe && !sampling_busy |=> sampling_busy [*8])
		else $error("sample not taken");
endmodule // imu_regs_properties
`default_nettype wire

// *** tb/imu_host_model.sv ***
/* Host processor model: one-cycle strobes set on the falling edge.
   Assumes a read is answered one cycle after its strobe. */
`timescale 1ns/1ps
`default_nettype none
module imu_host_model (
	// Host port
	input  wire logic       core_clk,
	output var  logic [6:0] reg_addr,
	output var  logic       reg_wr,
	output var  logic       reg_rd,
	output var  logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	initial begin
		reg_addr = 7'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// Idle lines show the inverse so stale values cannot pass
	task wr(input logic [6:0] a, input logic [7:0] v);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~v;
	endtask
	task rd(input logic [6:0] a, output logic [7:0] v);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		v = reg_rvalid ? reg_rdata : 8'hxx;
	endtask
endmodule // imu_host_model
`default_nettype wire

// *** tb/imu_fifo_power_offset_regs_tb_top.sv ***
/* Self-checking bench for the register bank.
   Assumes the bank, host model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module imu_fifo_power_offset_regs_tb_top;
	localparam logic [7:0] ID = 8'h3c; // Arbitrary value
	logic core_clk = 1'b0, reset = 1'b1, sample_strobe = 1'b0, fifo_stop_when_full = 1'b0;
	logic address_select_pin = 1'b0, reg_wr, reg_rd, reg_rvalid, sampling_busy;
	logic buffer_overrun_flag, accel_x_off, accel_y_off, accel_z_off, two_wire_slave_off;
	logic gyro_x_off, gyro_y_off, gyro_z_off;
	logic [111:0] sample_bytes = '0;
	logic [13:0] capture_mask = '0;
	logic [14:0] accel_x_trim, accel_y_trim, accel_z_trim;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic [6:0] reg_addr, two_wire_address;
	int miscompares = 0, n_compared = 0, cycles = 0, overruns = 0, lvl = 0;
	imu_fifo_power_offset_regs #(.PART_IDENTITY_CODE(ID)) imu_fifo_power_offset_regs_i (
		.core_clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
		.sample_strobe, .sample_bytes, .capture_mask, .fifo_stop_when_full, .sampling_busy,
		.buffer_overrun_flag, .address_select_pin, .two_wire_address, .accel_x_off,
		.accel_y_off, .accel_z_off, .gyro_x_off, .gyro_y_off, .gyro_z_off,
		.two_wire_slave_off, .accel_x_trim, .accel_y_trim, .accel_z_trim);
	imu_host_model host_i (.core_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.reg_rvalid);
	always #10 core_clk = ~core_clk;
	always @(negedge core_clk) if (buffer_overrun_flag === 1'b1) overruns++;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 10000) begin
			miscompares++;
			wrap_up();
		end
	end
	task chk(string what, logic [15:0] seen, logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wrap_up;
		$display("Compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task do_reset;
		@(negedge core_clk);
		reset = 1'b1;
		repeat (4) @(negedge core_clk);
		reset = 1'b0;
	endtask
	task t_regs;
		host_i.wr(7'h6c, 8'he8);
		host_i.rd(7'h6c, d);
		chk("standby", d, 8'h28);
		chk("axis off", {accel_x_off, accel_y_off, accel_z_off, gyro_x_off, gyro_y_off, gyro_z_off}, 6'h28);
		host_i.wr(7'h70, 8'hff);
		host_i.rd(7'h70, d);
		chk("iface", d, 8'h40);
		chk("slave off", two_wire_slave_off, 1'b1);
		host_i.wr(7'h75, 8'h00);
		host_i.rd(7'h75, d);
		chk("identity", d, ID);
		host_i.rd(7'h6d, d);
		chk("unmapped", d, 8'h00);
		chk("address", two_wire_address, 7'h68);
		address_select_pin = 1'b1;
		@(negedge core_clk);
		chk("address", two_wire_address, 7'h69);
		for (int i = 0; i < 3; i++) begin
			host_i.wr(7'h77 + 7'(3 * i), 8'ha5);
			host_i.wr(7'h78 + 7'(3 * i), 8'hff);
			host_i.rd(7'h78 + 7'(3 * i), d);
			chk("trim low", d, 8'hfe);
			chk("trim", i == 0 ? accel_x_trim : i == 1 ? accel_y_trim : accel_z_trim, 15'h52ff);
		end
		$display("Register test done");
	endtask
	task t_fifo(input logic [13:0] m);
		host_i.rd(7'h74, d);
		chk("empty read", d, 8'hff);
		for (int k = 0; k < 14; k++)
			sample_bytes[8*k +: 8] = 8'hf2 + 8'(k);
		capture_mask = m;
		sample_strobe = 1'b1;
		@(negedge core_clk);
		sample_strobe = 1'b0;
		repeat (16) @(negedge core_clk);
		chk("busy", sampling_busy, 1'b0);
		host_i.rd(7'h73, d);
		chk("stale level", d, 8'(lvl));
		host_i.rd(7'h72, d);
		chk("level high", d, 8'h00);
		host_i.rd(7'h73, d);
		lvl = $countones(m);
		chk("level low", d, 8'(lvl));
		host_i.wr(7'h72, 8'hff);
		host_i.rd(7'h72, d);
		chk("level read-only", d, 8'h00);
		for (int k = 0; k < 14; k++)
			if (m[k]) begin
				host_i.rd(7'h74, d);
				chk("fifo byte", d, k == 13 ? 8'hfe : 8'hf2 + 8'(k));
			end
		host_i.rd(7'h74, d);
		chk("empty again", d, 8'hff);
		$display("FIFO test done");
	endtask
	task t_overflow(input logic stop);
		do_reset();
		fifo_stop_when_full = stop;
		overruns = 0;
		for (int i = 0; i < 1025; i++)
			host_i.wr(7'h74, 8'(i % 128));
		host_i.rd(7'h74, d);
		chk("overruns", 16'(overruns), 16'h0001);
		chk("oldest", d, stop ? 8'h00 : 8'h01);
		$display("Overflow test done");
	endtask
	initial begin
		do_reset();
		t_regs();
		t_fifo(14'h3fff);
		t_fifo(14'h3ffa);
		t_overflow(1'b1);
		t_overflow(1'b0);
		wrap_up();
	end
endmodule // imu_fifo_power_offset_regs_tb_top
bind imu_fifo_power_offset_regs imu_regs_properties chk_i (.core_clk, .reset, .reg_addr,
	.reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .sample_strobe, .sampling_busy,
	.address_select_pin, .two_wire_address, .accel_x_off, .accel_y_off, .accel_z_off,
	.gyro_x_off, .gyro_y_off, .gyro_z_off, .two_wire_slave_off, .accel_x_trim);
`default_nettype wire
